// ==== asc_pkg.sv ====
package asc_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned AXI_AW = 12;
   localparam logic [9:0] IDX_DATA = 10'h3f8;
   localparam logic [9:0] IDX_IER = 10'h3f9;
   localparam logic [9:0] IDX_IIR = 10'h3fa;
   localparam logic [9:0] IDX_LCR = 10'h3fb;
   localparam logic [9:0] IDX_MCR = 10'h3fc;
   localparam logic [9:0] IDX_LSR = 10'h3fd;
   localparam logic [9:0] IDX_MSR = 10'h3fe;
   localparam logic [9:0] IDX_SCR = 10'h3ff;
   localparam logic [6:0] IDX_BLOCK = 7'h7f;
   // line format and modem control fields
   localparam int unsigned LCR_DIVISOR_SELECT_BIT = 7;
   localparam int unsigned LCR_BRK = 6;
   localparam int unsigned LCR_STICK = 5;
   localparam int unsigned LCR_EVEN = 4;
   localparam int unsigned LCR_PEN = 3;
   localparam int unsigned LCR_STB = 2;
   localparam int unsigned MCR_LOOP = 4;
   // interrupt enable fields
   localparam int unsigned IER_MS = 3;
   localparam int unsigned IER_RLS = 2;
   localparam int unsigned IER_TX_HOLDING_EMPTY_FLAG = 1;
   localparam int unsigned IER_RDA = 0;
   // identification codes, highest priority first; then bus response codes
   localparam logic [1:0] ID_RLS = 2'h3;
   localparam logic [1:0] ID_RDA = 2'h2;
   localparam logic [1:0] ID_TX_HOLDING_EMPTY_FLAG = 2'h1;
   localparam logic [1:0] ID_MS = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // sixteen baud ticks per bit
   localparam logic [4:0] TICK_MID = 5'h07;
   localparam logic [4:0] TICK_LAST = 5'h0f;
   localparam logic [4:0] TICK_STOP15 = 5'h17;
   localparam logic [4:0] TICK_STOP2 = 5'h1f;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } asc_tx_e;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100,
      RX_BRK = 3'b101
   } asc_rx_e;

   typedef struct packed {
      logic aw_done;
      logic [9:0] aw_idx;
      logic w_done;
      logic [7:0] w_data;
      logic w_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] rbr;
      logic [7:0] transmit_holding;
      logic [7:0] dll;
      logic [7:0] dlm;
      logic [3:0] ier;
      logic [7:0] lcr;
      logic [4:0] modem_output_control;
      logic [7:0] scr;
      logic dr;
      logic oe;
      logic pe;
      logic fe;
      logic bi;
      logic tx_holding_empty_flag;
      logic tx_holding_empty_flag_ip;
      logic frz;
      logic [1:0] frz_id;
      logic irq;
      logic [3:0] msr_d;
      logic [3:0] ms_prev;
      logic [15:0] baud_cnt;
      asc_tx_e tx_st;
      logic [7:0] tx_sh;
      logic [4:0] tx_cnt;
      logic [2:0] tx_bit;
      logic tx_par;
      logic tx_out;
      logic tx_pin;
      asc_rx_e rx_st;
      logic [7:0] rx_sh;
      logic [4:0] rx_cnt;
      logic [2:0] rx_bit;
      logic rx_pbit;
      logic rx_zero;
   } asc_state_s;

   localparam asc_state_s ST_RST = '{
      tx_st: TX_IDLE,
      rx_st: RX_IDLE,
      tx_holding_empty_flag: 1'b1,
      tx_out: 1'b1,
      tx_pin: 1'b1,
      default: '0
   };
endpackage

// ==== asc_regs.sv ====
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module asc_regs (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [asc_pkg::AXI_AW-1:0] awaddr,
   // write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [asc_pkg::AXI_AW-1:0] araddr,
   // read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // serial line
   output logic serial_tx_pin,
   input wire logic serial_rx_pin,
   // modem lines, active low
   input wire logic cts_in_n,
   input wire logic dsr_in_n,
   input wire logic carrier_detect_in_n,
   input wire logic ring_in_n,
   output logic dtr_out_n,
   output logic rts_out_n,
   output logic user_out1_n,
   output logic user_out2_n,
   // interrupt
   output logic irq_out
);
   import asc_pkg::*;

   asc_state_s s;
   asc_state_s next_s;

   logic divisor_select_bit;
   logic loop;
   logic tick;
   logic rx_in;
   logic [1:0] wl;
   logic [2:0] last_bit;
   logic [4:0] stop_last;
   logic [15:0] div;
   logic [3:0] ms_cur;
   logic [3:0] pv;
   logic any_p;
   logic [1:0] live_id;
   logic [1:0] rep_id;
   logic [9:0] ar_idx;
   logic ar_ok;
   logic wr_ok;
   logic do_wr;
   logic wr_thr;
   logic rbr_rd;
   logic temt;

   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [7:0] lcr);
      logic [7:0] m;
      m = 8'hff >> (2'h3 - lcr[1:0]);
      if (lcr[LCR_STICK]) begin
         return ~lcr[LCR_EVEN];
      end
      return (^(d & m)) ^ ~lcr[LCR_EVEN];
   endfunction

   assign divisor_select_bit = s.lcr[LCR_DIVISOR_SELECT_BIT];
   assign loop = s.modem_output_control[MCR_LOOP];
   assign wl = s.lcr[1:0];
   assign last_bit = {1'b1, wl};
   // 1.5 stop bits only with five-bit characters
   assign stop_last = !s.lcr[LCR_STB] ? TICK_LAST :
                      (wl == 2'h0) ? TICK_STOP15 : TICK_STOP2;
   assign div = {s.dlm, s.dll};
   // a zero divisor stops the generator instead of dividing by 65536
   assign tick = (div != 16'h0000) && (s.baud_cnt <= 16'h0001);
   assign rx_in = loop ? s.tx_out : serial_rx_pin;
   // order dcd, ri, dsr, cts
   assign ms_cur = loop ? {s.modem_output_control[3], s.modem_output_control[2], s.modem_output_control[0], s.modem_output_control[1]} :
                   ~{carrier_detect_in_n, ring_in_n, dsr_in_n,
                     cts_in_n};
   assign temt = s.tx_holding_empty_flag && (s.tx_st == TX_IDLE);

   assign pv[ID_RLS] = s.ier[IER_RLS] &&
                       (s.oe || s.pe || s.fe || s.bi);
   assign pv[ID_RDA] = s.ier[IER_RDA] && s.dr;
   assign pv[ID_TX_HOLDING_EMPTY_FLAG] = s.ier[IER_TX_HOLDING_EMPTY_FLAG] && s.tx_holding_empty_flag_ip;
   assign pv[ID_MS] = s.ier[IER_MS] && (s.msr_d != 4'h0);
   assign any_p = (pv != 4'h0);
   assign live_id = pv[ID_RLS] ? ID_RLS :
                    pv[ID_RDA] ? ID_RDA :
                    pv[ID_TX_HOLDING_EMPTY_FLAG] ? ID_TX_HOLDING_EMPTY_FLAG : ID_MS;
   assign rep_id = (s.frz && pv[s.frz_id]) ? s.frz_id : live_id;

   assign ar_idx = araddr[AXI_AW-1:2];
   assign ar_ok = (ar_idx[9:3] == IDX_BLOCK);
   assign wr_ok = (s.aw_idx[9:3] == IDX_BLOCK);
   assign do_wr = s.aw_done && s.w_done && !s.bvalid;
   assign wr_thr = do_wr && wr_ok && s.w_en && !divisor_select_bit &&
                   (s.aw_idx == IDX_DATA);
   assign rbr_rd = arvalid && !s.rvalid && !divisor_select_bit &&
                   (ar_idx == IDX_DATA);

   assign awready = !s.aw_done && !s.bvalid;
   assign wready = !s.w_done && !s.bvalid;
   assign arready = !s.rvalid;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rdata = {24'h000000, s.rdata};
   assign rresp = s.rresp;
   assign serial_tx_pin = s.tx_pin;
   // loopback disconnects the modem outputs, leaving them inactive
   assign dtr_out_n = !(s.modem_output_control[0] && !loop);
   assign rts_out_n = !(s.modem_output_control[1] && !loop);
   assign user_out1_n = !(s.modem_output_control[2] && !loop);
   assign user_out2_n = !(s.modem_output_control[3] && !loop);
   assign irq_out = s.irq;

   always_comb begin
      next_s = s;
      // software side first, so hardware sets below win
      if (awvalid && awready) begin
         next_s.aw_done = 1'b1;
         next_s.aw_idx = awaddr[AXI_AW-1:2];
      end
      if (wvalid && wready) begin
         next_s.w_done = 1'b1;
         next_s.w_data = wdata[7:0];
         next_s.w_en = wstrb[0];
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.frz && !pv[s.frz_id]) begin
         next_s.frz = 1'b0;
      end
      if (do_wr) begin
         next_s.aw_done = 1'b0;
         next_s.w_done = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
         if (wr_ok && s.w_en) begin
            case (s.aw_idx)
               IDX_DATA: begin
                  if (divisor_select_bit) begin
                     next_s.dll = s.w_data;
                  end else begin
                     next_s.transmit_holding = s.w_data;
                     next_s.tx_holding_empty_flag = 1'b0;
                     next_s.tx_holding_empty_flag_ip = 1'b0;
                  end
               end
               IDX_IER: begin
                  if (divisor_select_bit) begin
                     next_s.dlm = s.w_data;
                  end else begin
                     next_s.ier = s.w_data[3:0];
                     // enabling while already empty reports at once
                     if (s.w_data[IER_TX_HOLDING_EMPTY_FLAG] && !s.ier[IER_TX_HOLDING_EMPTY_FLAG] &&
                         s.tx_holding_empty_flag) begin
                        next_s.tx_holding_empty_flag_ip = 1'b1;
                     end
                  end
               end
               IDX_LCR: next_s.lcr = s.w_data;
               IDX_MCR: next_s.modem_output_control = s.w_data[4:0];
               IDX_LSR: begin
                  if (loop) begin
                     next_s.dr = s.w_data[0];
                     next_s.oe = s.w_data[1];
                     next_s.pe = s.w_data[2];
                     next_s.fe = s.w_data[3];
                     next_s.bi = s.w_data[4];
                     next_s.tx_holding_empty_flag = s.w_data[5];
                     if (s.w_data[5] && !s.tx_holding_empty_flag) begin
                        next_s.tx_holding_empty_flag_ip = 1'b1;
                     end
                  end
               end
               IDX_MSR: begin
                  if (loop) begin
                     next_s.msr_d = s.w_data[3:0];
                  end
               end
               IDX_SCR: next_s.scr = s.w_data;
               default: begin
               end
            endcase
         end
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = ar_ok ? RESP_OKAY : RESP_SLVERR;
         next_s.rdata = 8'h00;
         case (ar_idx)
            IDX_DATA: begin
               next_s.rdata = divisor_select_bit ? s.dll : s.rbr;
               if (!divisor_select_bit) begin
                  next_s.dr = 1'b0;
               end
            end
            IDX_IER: next_s.rdata = divisor_select_bit ? s.dlm : {4'h0, s.ier};
            IDX_IIR: begin
               next_s.rdata = {5'h00, rep_id, !any_p};
               next_s.frz = any_p;
               next_s.frz_id = rep_id;
               if (any_p && rep_id == ID_TX_HOLDING_EMPTY_FLAG) begin
                  next_s.tx_holding_empty_flag_ip = 1'b0;
               end
            end
            IDX_LCR: next_s.rdata = s.lcr;
            IDX_MCR: next_s.rdata = {3'h0, s.modem_output_control};
            IDX_LSR: begin
               next_s.rdata = {1'b0, temt, s.tx_holding_empty_flag, s.bi, s.fe, s.pe,
                               s.oe, s.dr};
               next_s.oe = 1'b0;
               next_s.pe = 1'b0;
               next_s.fe = 1'b0;
               next_s.bi = 1'b0;
            end
            IDX_MSR: begin
               next_s.rdata = {ms_cur, s.msr_d};
               next_s.msr_d = 4'h0;
            end
            IDX_SCR: next_s.rdata = s.scr;
            default: next_s.rdata = 8'h00;
         endcase
      end
      // baud generator
      if (do_wr && wr_ok && s.w_en && divisor_select_bit &&
          (s.aw_idx == IDX_DATA || s.aw_idx == IDX_IER)) begin
         next_s.baud_cnt = {next_s.dlm, next_s.dll};
      end else if (tick) begin
         next_s.baud_cnt = div;
      end else if (div != 16'h0000) begin
         next_s.baud_cnt = s.baud_cnt - 16'h0001;
      end
      // transmitter
      if (tick) begin
         next_s.tx_cnt = s.tx_cnt + 5'h01;
      end
      unique case (s.tx_st)
         TX_IDLE: begin
            // a write in the same cycle would be lost, so wait one
            if (!s.tx_holding_empty_flag && !wr_thr) begin
               next_s.tx_sh = s.transmit_holding;
               next_s.tx_holding_empty_flag = 1'b1;
               next_s.tx_holding_empty_flag_ip = 1'b1;
               next_s.tx_par = par_bit(s.transmit_holding, s.lcr);
               next_s.tx_out = 1'b0;
               next_s.tx_cnt = 5'h00;
               next_s.tx_bit = 3'h0;
               next_s.tx_st = TX_START;
            end
         end
         TX_START: begin
            if (tick && s.tx_cnt == TICK_LAST) begin
               next_s.tx_cnt = 5'h00;
               next_s.tx_out = s.tx_sh[0];
               next_s.tx_st = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tick && s.tx_cnt == TICK_LAST) begin
               next_s.tx_cnt = 5'h00;
               if (s.tx_bit == last_bit) begin
                  next_s.tx_st = s.lcr[LCR_PEN] ? TX_PAR : TX_STOP;
                  next_s.tx_out = s.lcr[LCR_PEN] ? s.tx_par : 1'b1;
               end else begin
                  next_s.tx_bit = s.tx_bit + 3'h1;
                  next_s.tx_sh = s.tx_sh >> 1;
                  next_s.tx_out = s.tx_sh[1];
               end
            end
         end
         TX_PAR: begin
            if (tick && s.tx_cnt == TICK_LAST) begin
               next_s.tx_cnt = 5'h00;
               next_s.tx_out = 1'b1;
               next_s.tx_st = TX_STOP;
            end
         end
         TX_STOP: begin
            if (tick && s.tx_cnt == stop_last) begin
               next_s.tx_st = TX_IDLE;
            end
         end
         default: next_s.tx_st = TX_IDLE;
      endcase
      if (loop) begin
         next_s.tx_pin = 1'b1;
      end else if (s.lcr[LCR_BRK]) begin
         next_s.tx_pin = 1'b0;
      end else begin
         next_s.tx_pin = next_s.tx_out;
      end
      // receiver
      if (tick) begin
         next_s.rx_cnt = s.rx_cnt + 5'h01;
      end
      unique case (s.rx_st)
         RX_IDLE: begin
            if (tick && !rx_in) begin
               next_s.rx_cnt = 5'h00;
               next_s.rx_st = RX_START;
            end
         end
         RX_START: begin
            // a start bit shorter than half a bit is noise
            if (tick && s.rx_cnt == TICK_MID) begin
               next_s.rx_cnt = 5'h00;
               next_s.rx_bit = 3'h0;
               next_s.rx_sh = 8'h00;
               next_s.rx_zero = 1'b1;
               next_s.rx_st = rx_in ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (tick && s.rx_cnt == TICK_LAST) begin
               next_s.rx_cnt = 5'h00;
               next_s.rx_sh[s.rx_bit] = rx_in;
               next_s.rx_zero = s.rx_zero && !rx_in;
               if (s.rx_bit == last_bit) begin
                  next_s.rx_st = s.lcr[LCR_PEN] ? RX_PAR : RX_STOP;
               end else begin
                  next_s.rx_bit = s.rx_bit + 3'h1;
               end
            end
         end
         RX_PAR: begin
            if (tick && s.rx_cnt == TICK_LAST) begin
               next_s.rx_cnt = 5'h00;
               next_s.rx_pbit = rx_in;
               next_s.rx_zero = s.rx_zero && !rx_in;
               next_s.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            // only the first stop bit is checked
            if (tick && s.rx_cnt == TICK_LAST) begin
               next_s.rbr = s.rx_sh;
               next_s.dr = 1'b1;
               if (s.dr && !rbr_rd) begin
                  next_s.oe = 1'b1;
               end
               if (s.lcr[LCR_PEN] &&
                   s.rx_pbit != par_bit(s.rx_sh, s.lcr)) begin
                  next_s.pe = 1'b1;
               end
               if (!rx_in) begin
                  next_s.fe = 1'b1;
               end
               if (s.rx_zero && !rx_in) begin
                  next_s.bi = 1'b1;
                  next_s.rx_st = RX_BRK;
               end else begin
                  next_s.rx_st = RX_IDLE;
               end
            end
         end
         RX_BRK: begin
            if (rx_in) begin
               next_s.rx_st = RX_IDLE;
            end
         end
         default: next_s.rx_st = RX_IDLE;
      endcase
      // modem status deltas
      next_s.ms_prev = ms_cur;
      next_s.msr_d[0] = next_s.msr_d[0] ||
                        (ms_cur[0] != s.ms_prev[0]);
      next_s.msr_d[1] = next_s.msr_d[1] ||
                        (ms_cur[1] != s.ms_prev[1]);
      next_s.msr_d[2] = next_s.msr_d[2] ||
                        (s.ms_prev[2] && !ms_cur[2]);
      next_s.msr_d[3] = next_s.msr_d[3] ||
                        (ms_cur[3] != s.ms_prev[3]);
      next_s.irq = any_p;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ==== asc_regs_props.sv ====
`timescale 1ns/1ps
module asc_regs_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [asc_pkg::AXI_AW-1:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // pins
   input wire logic serial_tx_pin,
   input wire logic dtr_out_n,
   input wire logic rts_out_n,
   input wire logic user_out1_n,
   input wire logic user_out2_n,
   input wire logic irq_out
);
   import asc_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_reset_quiet;
      $rose(aresetn) |-> !irq_out && serial_tx_pin &&
         (&{dtr_out_n, rts_out_n, user_out1_n, user_out2_n});
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active after reset");
   property p_bresp_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold)
      else $error("write response dropped early");
   property p_rdata_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data dropped early");
   property p_ar_block;
      rvalid |-> !arready;
   endproperty
   a_ar_block: assert property (p_ar_block)
      else $error("read address taken while data waits");
   property p_w_block;
      bvalid |-> !awready && !wready;
   endproperty
   a_w_block: assert property (p_w_block)
      else $error("write taken while response waits");
   property p_read_answer;
      arvalid && arready |=> rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");
   property p_write_answer;
      awvalid && awready && wvalid && wready |-> ##[1:3] bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write answer late");
   property p_upper_zero;
      rvalid |-> rdata[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read bits not zero");
   property p_unmapped;
      arvalid && arready && araddr[11:5] != IDX_BLOCK |=>
         rresp == RESP_SLVERR && rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
endmodule

bind asc_regs asc_regs_props u_asc_regs_props (.aclk, .aresetn, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
   .araddr, .rvalid, .rready, .rdata, .rresp, .serial_tx_pin, .dtr_out_n,
   .rts_out_n, .user_out1_n, .user_out2_n, .irq_out);

// ==== asc_modem_model.sv ====
`timescale 1ns/1ps
module asc_modem_model #(
   parameter int BIT_CYC = 16
) (
   // clock
   input wire logic aclk,
   // serial line toward the block
   output logic serial_rx_pin,
   // modem lines, active low
   output logic cts_in_n,
   output logic dsr_in_n,
   output logic carrier_detect_in_n,
   output logic ring_in_n
);
   initial begin
      serial_rx_pin = 1'b1;
      {carrier_detect_in_n, ring_in_n, dsr_in_n, cts_in_n} = 4'hf;
   end
   // 8 data bits, no parity; a bad stop is cut short so no false start
   task automatic send(input logic [7:0] d, input logic good_stop);
      logic [9:0] f;
      f = {good_stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge aclk);
         serial_rx_pin <= f[i];
         repeat ((i == 9 && !good_stop) ? BIT_CYC / 2 + 3 : BIT_CYC - 1)
            @(posedge aclk);
      end
      @(posedge aclk);
      serial_rx_pin <= 1'b1;
      repeat (BIT_CYC) @(posedge aclk);
   endtask
   task automatic lines(input logic [3:0] v);
      @(posedge aclk);
      {carrier_detect_in_n, ring_in_n, dsr_in_n, cts_in_n} <= v;
   endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import asc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rv;
   logic [3:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, serial_tx_pin;
   logic serial_rx_pin, cts_in_n, dsr_in_n, carrier_detect_in_n, ring_in_n;
   logic dtr_out_n, rts_out_n, user_out1_n, user_out2_n, irq_out;
   logic [1:0] bresp, rresp, rsp;
   logic [9:0] fr, ex, d;
   logic [7:0] lc [6] = '{8'h03, 8'h1b, 8'h0b, 8'h08, 8'h3b, 8'h2b};
   logic pb;
   int error_cnt = 0;
   int tests_run = 0;
   int wl, nb;
   always #12.5 aclk = ~aclk;
   asc_regs u_asc_regs (.aclk, .aresetn, .awvalid, .awready, .awaddr,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .serial_tx_pin,
      .serial_rx_pin, .cts_in_n, .dsr_in_n, .carrier_detect_in_n,
      .ring_in_n, .dtr_out_n, .rts_out_n, .user_out1_n, .user_out2_n,
      .irq_out);
   asc_modem_model u_asc_modem_model (.aclk, .serial_rx_pin, .cts_in_n,
      .dsr_in_n, .carrier_detect_in_n, .ring_in_n);
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang();
      error_cnt++;
      $display("mismatch at %0t: wait ran out", $time);
      test_done();
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      int n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, v};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      rsp = bresp;
      bready <= 1'b0;
      if (n >= 50) hang();
   endtask
   task automatic rd(input logic [9:0] idx);
      int n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rv = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n >= 50) hang();
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
      rd(idx);
      chk(rv, {24'h0, e});
   endtask
   // waits for a start bit, then samples each bit near its middle
   task automatic cap(input int bits);
      int n = 0;
      fr = '1;
      while (serial_tx_pin !== 1'b0 && n < 400) begin
         @(negedge aclk);
         n++;
      end
      if (n >= 400) hang();
      repeat (8) @(negedge aclk);
      for (int i = 0; i < bits; i++) begin
         repeat (16) @(negedge aclk);
         fr[i] = serial_tx_pin;
      end
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({irq_out, serial_tx_pin, dtr_out_n, user_out2_n}, 4'h7);
      rdc(IDX_IER, 8'h00);
      rdc(IDX_LCR, 8'h00);
      rdc(IDX_IIR, 8'h01);
      rdc(IDX_LSR, 8'h60);
      rd(10'h3f0);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(10'h3f0, 8'h55);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(IDX_LCR, 8'h80);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      wr(IDX_LCR, 8'h80);
      wr(IDX_DATA, 8'h34);
      wr(IDX_IER, 8'h12);
      rdc(IDX_DATA, 8'h34);
      rdc(IDX_IER, 8'h12);
      wr(IDX_DATA, 8'h01);
      wr(IDX_IER, 8'h00);
      wr(IDX_LCR, 8'h03);
      rdc(IDX_LCR, 8'h03);
      wr(IDX_IER, 8'hff);
      rdc(IDX_IER, 8'h0f);
      wr(IDX_IER, 8'h02);
      repeat (3) @(posedge aclk);
      chk(irq_out, 1'b1);
      rdc(IDX_IIR, 8'h02);
      rdc(IDX_IIR, 8'h01);
      wr(IDX_IER, 8'h00);
      $display("end of register test");
      d = 10'h0a5;
      for (int k = 0; k < 6; k++) begin
         wr(IDX_LCR, lc[k]);
         wr(IDX_DATA, d[7:0]);
         wl = 5 + lc[k][1:0];
         pb = lc[k][5] ? ~lc[k][4] : (^(d & ~(10'h3ff << wl))) ^ ~lc[k][4];
         nb = wl + lc[k][3] + 1;
         for (int i = 0; i < 10; i++)
            ex[i] = (i < wl) ? d[i] : (i == wl && lc[k][3]) ? pb : 1'b1;
         cap(nb);
         fr = fr & ~(10'h3ff << nb);
         ex = ex & ~(10'h3ff << nb);
         chk({22'h0, fr}, {22'h0, ex});
         repeat (60) @(posedge aclk);
      end
      wr(IDX_LCR, 8'h43);
      repeat (3) @(posedge aclk);
      chk(serial_tx_pin, 1'b0);
      wr(IDX_LCR, 8'h03);
      repeat (3) @(posedge aclk);
      chk(serial_tx_pin, 1'b1);
      $display("end of transmit test");
      u_asc_modem_model.send(8'h3c, 1'b1);
      u_asc_modem_model.send(8'h81, 1'b0);
      chk(irq_out, 1'b0);
      wr(IDX_IER, 8'h05);
      rdc(IDX_IIR, 8'h06);
      rdc(IDX_LSR, 8'h6b);
      rdc(IDX_LSR, 8'h61);
      rdc(IDX_IIR, 8'h04);
      rdc(IDX_DATA, 8'h81);
      rdc(IDX_IIR, 8'h01);
      $display("end of receive test");
      wr(IDX_IER, 8'h08);
      u_asc_modem_model.lines(4'he);
      repeat (4) @(posedge aclk);
      chk(irq_out, 1'b1);
      rdc(IDX_IIR, 8'h00);
      rdc(IDX_MSR, 8'h11);
      // interrupt output is registered, so it drops one cycle later
      repeat (2) @(posedge aclk);
      chk(irq_out, 1'b0);
      u_asc_modem_model.lines(4'ha);
      repeat (3) @(posedge aclk);
      rdc(IDX_MSR, 8'h50);
      u_asc_modem_model.lines(4'he);
      repeat (3) @(posedge aclk);
      rdc(IDX_MSR, 8'h14);
      u_asc_modem_model.lines(4'hf);
      repeat (3) @(posedge aclk);
      rdc(IDX_MSR, 8'h01);
      wr(IDX_IER, 8'h00);
      wr(IDX_MCR, 8'h0f);
      chk({dtr_out_n, rts_out_n, user_out1_n, user_out2_n}, 4'h0);
      $display("end of modem test");
      wr(IDX_MCR, 8'hff);
      rdc(IDX_MCR, 8'h1f);
      chk({serial_tx_pin, dtr_out_n, rts_out_n, user_out2_n}, 4'hf);
      rd(IDX_MSR);
      rdc(IDX_MSR, 8'hf0);
      wr(IDX_DATA, 8'h5a);
      repeat (40) @(posedge aclk);
      chk(serial_tx_pin, 1'b1);
      repeat (200) @(posedge aclk);
      rdc(IDX_DATA, 8'h5a);
      wr(IDX_IER, 8'h04);
      wr(IDX_LSR, 8'h30);
      repeat (3) @(posedge aclk);
      chk(irq_out, 1'b1);
      rdc(IDX_IIR, 8'h06);
      rd(IDX_LSR);
      rdc(IDX_IIR, 8'h01);
      $display("end of loopback test");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(IDX_MCR, 8'h00);
      chk({irq_out, dtr_out_n, user_out1_n}, 3'h3);
      $display("end of reset test");
      test_done();
   end
endmodule
